//--- rtl/sdac_control.sv
// Purpose: digital control of a bridge-sensor sigma-delta converter
// Assumes: serial pins come from the host domain; raw words from the filter
// Notes: register access other than the data word stays outside this block
//
// Summary of operation
// - keep decoding data-in during continuous read
// - 32 consecutive ones on data-in cause reset
// - reset clears logic, filter, modulator, registers
// - power-up reset acts like commanded reset
// - unipolar output is straight binary
// - bipolar output is offset binary
// - word width 16 or 24 bits
// - polarity bit picks unipolar or bipolar coding
// - burnout enable switches both current sources
// - channel 111 converts supply, internal reference
// - channel 110 converts temperature, internal reference
// - three calibrations: internal zero, system zero, full
// - subtract offset then multiply by full-scale
// - calibration write starts it, ready goes high
// - calibration end updates coefficient, ready, then idle
// - 01011100 enters continuous read, words flow unasked
// - offset and full-scale calibrations take two conversions
`timescale 1ns/1ps
module sdac_control #(
   parameter int N = sdac_pkg::WORD_W_DEF
) (
   // clock and reset
   input logic clk,
   input logic srst,
   // serial pins
   input sdac_pkg::sdac_pins_t pins,
   output logic doutRdy,
   output logic doutRdyEn,
   // configuration and mode
   input sdac_pkg::sdac_cfg_t cfg,
   input logic modeLoad,
   input logic [2:0] operatingMode,
   output logic [2:0] modeNow,
   output logic calBusy,
   output logic contRead,
   output logic statusReadyN,
   // analog front end
   output sdac_pkg::sdac_front_t front,
   output logic analogReset,
   // filter results
   input logic rawValid,
   input logic signed [N-1:0] rawData,
   output logic rawReady,
   // data and coefficients
   output logic [N-1:0] dataWord,
   output logic signed [N-1:0] offsetCoef,
   output logic [sdac_pkg::FS_W-1:0] fullScaleCoef
);
   import sdac_pkg::*;

   localparam int PW = N + FS_W + 2;
   localparam int DW = N + FS_FRAC;
   localparam int CW = $clog2(N + 1);
   localparam int BW = $clog2(CMD_W);
   localparam int OW = $clog2(ONES_RESET_BITS + 1);
   localparam int VW = $clog2(CAL_CONVS + 1);
   localparam int KW = $clog2(DW);
   localparam logic signed [PW-1:0] CODE_HALF = {{(PW-N){1'b0}}, 1'b1, {(N-1){1'b0}}};
   localparam logic signed [PW-1:0] CODE_MAX = {{(PW-N){1'b0}}, {N{1'b1}}};

   // ------------------------------
   // pin synchroniser and edges
   // ------------------------------
   sdac_pins_t pinsMeta;
   sdac_pins_t pinsSync;
   sdac_pins_t pinsLast;
   logic sclkRise;
   logic sclkFall;
   logic selected;

   always_ff @(posedge clk) begin
      if (srst) begin
         pinsMeta <= PINS_IDLE;
         pinsSync <= PINS_IDLE;
         pinsLast <= PINS_IDLE;
      end else begin
         pinsMeta <= pins;
         pinsSync <= pinsMeta;
         pinsLast <= pinsSync;
      end
   end

   assign sclkRise = pinsSync.sclk & ~pinsLast.sclk;
   assign sclkFall = ~pinsSync.sclk & pinsLast.sclk;
   assign selected = ~pinsSync.csN;

   // ------------------------------
   // ones-run reset
   // ------------------------------
   logic [OW-1:0] onesCnt;
   logic softRst;
   logic rstAll;

   always_ff @(posedge clk) begin
      if (srst) begin
         onesCnt <= '0;
         softRst <= 1'b0;
      end else begin
         softRst <= 1'b0;
         if (!selected) begin
            onesCnt <= '0;
         end else if (sclkRise) begin
            if (!pinsSync.din) begin
               onesCnt <= '0;
            end else if (onesCnt == OW'(ONES_RESET_BITS - 1)) begin
               onesCnt <= '0;
               softRst <= 1'b1;
            end else begin
               onesCnt <= onesCnt + 1'b1;
            end
         end
      end
   end

   // power-up and commanded reset share one path
   assign rstAll = srst | softRst;

   always_ff @(posedge clk) begin
      analogReset <= rstAll;
   end

   // ------------------------------
   // result scaling and coding
   // ------------------------------
   logic signed [N:0] diff;
   logic signed [PW-1:0] prod;
   logic signed [PW-1:0] scaled;
   logic signed [PW-1:0] pre;
   logic [N-1:0] coded;
   logic [N-1:0] nomCode;

   always_comb begin
      diff = $signed({rawData[N-1], rawData}) - $signed({offsetCoef[N-1], offsetCoef});
      prod = diff * $signed({1'b0, fullScaleCoef});
      scaled = prod >>> FS_FRAC;
      pre = cfg.unipolar ? (scaled <<< 1) : (scaled + CODE_HALF);
      if (pre < 0) begin
         coded = '0;
      end else if (pre > CODE_MAX) begin
         coded = '1;
      end else begin
         coded = pre[N-1:0];
      end
   end

   assign nomCode = {~diff[N-1], diff[N-2:0]};

   // ------------------------------
   // result stage and buffer
   // ------------------------------
   sdac_cal_t calState;
   logic accept;
   logic stgValid;
   logic next_stgValid;
   logic [N-1:0] stgWord;
   logic fifoInReady;
   logic fifoValid;
   logic [N-1:0] fifoWord;
   logic popOk;
   logic dataLoad;
   logic shifting;
   sdac_ser_t serState;

   assign accept = rawValid & rawReady;
   assign next_stgValid = (accept & (calState == CAL_OFF)) | (stgValid & ~fifoInReady);

   always_ff @(posedge clk) begin
      if (rstAll) begin
         stgValid <= 1'b0;
         rawReady <= 1'b1;
         stgWord <= '0;
      end else begin
         stgValid <= next_stgValid;
         rawReady <= ~next_stgValid;
         if (accept && calState == CAL_OFF) begin
            stgWord <= coded;
         end
      end
   end

   sdac_fifo2 #(
      .W(N),
      .DEPTH(2)
   ) u_buf (
      .clk(clk),
      .srst(rstAll),
      .inValid(stgValid),
      .inData(stgWord),
      .inReady(fifoInReady),
      .outValid(fifoValid),
      .outData(fifoWord),
      .outReady(popOk)
   );

   // the data register never changes under a word being shifted out
   assign popOk = ~shifting & (serState != SER_OUT) & (calState == CAL_OFF);
   assign dataLoad = fifoValid & popOk;

   always_ff @(posedge clk) begin
      if (rstAll) begin
         dataWord <= '0;
      end else if (dataLoad) begin
         dataWord <= fifoWord;
      end
   end

   // ------------------------------
   // calibration
   // ------------------------------
   logic [VW-1:0] calConv;
   logic [KW-1:0] divCnt;
   logic [N:0] divisor;
   logic [N:0] rem;
   logic [DW-1:0] quo;
   logic [N+1:0] trial;
   logic [N+1:0] remNext;
   logic qBit;
   logic [DW-1:0] qNext;
   logic isCal;
   logic calStart;
   logic lastConv;
   logic calDone;

   assign isCal = (operatingMode == MODE_ZS_INT) || (operatingMode == MODE_ZS_SYS)
      || (operatingMode == MODE_FS_SYS);
   assign calStart = modeLoad & isCal & (calState == CAL_OFF);
   assign lastConv = (calConv == VW'(CAL_CONVS - 1));
   assign calDone = (calState == CAL_WAIT && accept && lastConv && modeNow != MODE_FS_SYS)
      || (calState == CAL_DIV && divCnt == KW'(DW - 1));

   always_comb begin
      // dividend is a single one at its top bit
      trial = {rem, divCnt == '0};
      qBit = (trial >= {1'b0, divisor});
      remNext = qBit ? trial - {1'b0, divisor} : trial;
      qNext = {quo[DW-2:0], qBit};
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         calState <= CAL_OFF;
         calConv <= '0;
         modeNow <= MODE_CONT;
         divCnt <= '0;
      end else begin
         case (calState)
            CAL_OFF: begin
               if (modeLoad) begin
                  modeNow <= operatingMode;
               end else if (dataLoad && modeNow == MODE_SINGLE) begin
                  modeNow <= MODE_PDOWN;
               end
               if (calStart) begin
                  calState <= CAL_WAIT;
                  calConv <= '0;
               end
            end
            CAL_WAIT: begin
               if (accept) begin
                  calConv <= calConv + 1'b1;
                  if (lastConv && modeNow == MODE_FS_SYS) begin
                     calState <= CAL_DIV;
                     divCnt <= '0;
                  end else if (lastConv) begin
                     calState <= CAL_OFF;
                     modeNow <= MODE_IDLE;
                  end
               end
            end
            CAL_DIV: begin
               divCnt <= divCnt + 1'b1;
               if (calDone) begin
                  calState <= CAL_OFF;
                  modeNow <= MODE_IDLE;
               end
            end
            default: calState <= CAL_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         calBusy <= 1'b0;
      end else begin
         calBusy <= (calState != CAL_OFF) ? ~calDone : calStart;
      end
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         offsetCoef <= OFFSET_DEF[N-1:0];
         fullScaleCoef <= FS_NOM;
         divisor <= '0;
         rem <= '0;
         quo <= '0;
      end else if (calState == CAL_WAIT && accept && lastConv) begin
         if (modeNow == MODE_FS_SYS) begin
            divisor <= diff;
            rem <= '0;
            quo <= '0;
         end else begin
            offsetCoef <= rawData;
         end
      end else if (calState == CAL_DIV) begin
         rem <= remNext[N:0];
         quo <= qNext;
         if (calDone) begin
            // a tiny measured span would need a gain beyond the coefficient range
            fullScaleCoef <= (|qNext[DW-1:FS_W]) ? '1 : qNext[FS_W-1:0];
         end
      end
   end

   // ------------------------------
   // ready flag
   // ------------------------------
   logic readDone;

   always_ff @(posedge clk) begin
      if (rstAll) begin
         statusReadyN <= 1'b1;
      end else if (calStart) begin
         statusReadyN <= 1'b1;
      end else if (dataLoad || calDone) begin
         statusReadyN <= 1'b0;
      end else if (readDone) begin
         statusReadyN <= 1'b1;
      end
   end

   // ------------------------------
   // command receiver
   // ------------------------------
   logic [CMD_W-1:0] cmdShift;
   logic [BW-1:0] cmdBits;
   logic byteDone;
   logic [CMD_W-1:0] cmdByte;

   assign cmdByte = {cmdShift[CMD_W-2:0], pinsSync.din};
   assign byteDone = selected & sclkRise & (cmdBits == BW'(CMD_W - 1)) & (serState != SER_OUT);

   always_ff @(posedge clk) begin
      if (rstAll || !selected) begin
         cmdShift <= '0;
         cmdBits <= '0;
      end else if (sclkRise && serState != SER_OUT) begin
         cmdShift <= cmdByte;
         cmdBits <= cmdBits + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         serState <= SER_CMD;
         contRead <= 1'b0;
      end else begin
         case (serState)
            SER_CMD: begin
               if (byteDone && cmdByte == CMD_READ_DATA) begin
                  serState <= SER_OUT;
               end else if (byteDone && cmdByte == CMD_CONT_READ) begin
                  serState <= SER_CONT;
                  contRead <= 1'b1;
               end
            end
            SER_OUT: begin
               if (readDone || !selected) begin
                  serState <= SER_CMD;
               end
            end
            SER_CONT: begin
               if (byteDone && cmdByte == CMD_CONT_EXIT) begin
                  serState <= SER_CMD;
                  contRead <= 1'b0;
               end
            end
            default: serState <= SER_CMD;
         endcase
      end
   end

   // ------------------------------
   // word shifter and output pin
   // ------------------------------
   logic [N-1:0] outShift;
   logic [CW-1:0] outBits;
   logic wordArmed;
   logic loadWord;

   // in continuous read a fresh word goes out with no command
   assign wordArmed = (serState == SER_OUT) || (serState == SER_CONT && !statusReadyN);
   assign loadWord = selected & sclkFall & wordArmed & ~shifting;
   assign readDone = selected & sclkRise & shifting & (outBits == CW'(N - 1));

   always_ff @(posedge clk) begin
      if (rstAll || !selected) begin
         shifting <= 1'b0;
         outBits <= '0;
         outShift <= '0;
      end else if (loadWord) begin
         shifting <= 1'b1;
         outShift <= dataWord;
      end else if (readDone) begin
         shifting <= 1'b0;
         outBits <= '0;
      end else if (sclkRise && shifting) begin
         outShift <= outShift << 1;
         outBits <= outBits + 1'b1;
      end
   end

   // bits change just after the rising edge, a full period before sampling
   always_ff @(posedge clk) begin
      if (rstAll) begin
         doutRdy <= 1'b1;
         doutRdyEn <= 1'b0;
      end else begin
         doutRdyEn <= selected;
         if (loadWord) begin
            doutRdy <= dataWord[N-1];
         end else if (sclkRise && shifting && !readDone) begin
            doutRdy <= outShift[N-2];
         end else if (!shifting) begin
            doutRdy <= statusReadyN;
         end
      end
   end

   // ------------------------------
   // front-end controls
   // ------------------------------
   always_ff @(posedge clk) begin
      if (rstAll) begin
         front <= '0;
      end else begin
         front.burnoutSource <= cfg.burnoutEnable;
         front.burnoutSink <= cfg.burnoutEnable;
         front.supplyMonitor <= (cfg.channelSelect == CHAN_SUPPLY);
         front.tempSensor <= (cfg.channelSelect == CHAN_TEMP);
         front.internalRef <= (cfg.channelSelect == CHAN_SUPPLY)
            || (cfg.channelSelect == CHAN_TEMP);
      end
   end

   // ------------------------------
   // checks
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rstAll);

   chk_ones_run: assert property (disable iff (srst)
      selected && sclkRise && pinsSync.din && onesCnt == OW'(ONES_RESET_BITS - 1) |=> softRst)
      else $error("ones run did not reset");
   chk_reset_clears: assert property ($past(softRst) |->
      serState == SER_CMD && !contRead && fullScaleCoef == FS_NOM && analogReset
      && modeNow == MODE_CONT && statusReadyN)
      else $error("commanded reset left state");
   chk_powerup_state: assert property ($fell(srst) |->
      statusReadyN && calState == CAL_OFF && !contRead && offsetCoef == '0)
      else $error("power-up state wrong");
   chk_cont_enter: assert property (serState == SER_CMD && byteDone
      && cmdByte == CMD_CONT_READ |=> serState == SER_CONT && contRead)
      else $error("continuous read not entered");
   chk_cont_exit: assert property (serState == SER_CONT && byteDone
      && cmdByte == CMD_CONT_EXIT |=> serState == SER_CMD && !contRead)
      else $error("continuous read not left");
   chk_nominal_scale: assert property (accept && calState == CAL_OFF
      && !cfg.unipolar && fullScaleCoef == FS_NOM && diff[N] == diff[N-1]
      |=> stgWord == $past(nomCode))
      else $error("bipolar scaling wrong");
   chk_unipolar_low: assert property (accept && calState == CAL_OFF
      && cfg.unipolar && diff <= 0 |=> stgWord == '0)
      else $error("unipolar floor wrong");
   chk_clamp_high: assert property (accept && calState == CAL_OFF
      && pre > CODE_MAX |=> stgWord == '1)
      else $error("top clamp missing");
   chk_burnout_pair: assert property ($changed(cfg.burnoutEnable) |=>
      front.burnoutSource == $past(cfg.burnoutEnable) && front.burnoutSink == front.burnoutSource)
      else $error("burnout sources disagree");
   chk_supply_chan: assert property (cfg.channelSelect == CHAN_SUPPLY |=>
      front.supplyMonitor && front.internalRef && !front.tempSensor)
      else $error("supply channel wrong");
   chk_cal_start: assert property (calStart |=>
      statusReadyN && calState == CAL_WAIT && calBusy ##1 statusReadyN)
      else $error("calibration start wrong");
   chk_cal_done: assert property (calDone |=>
      !statusReadyN && modeNow == MODE_IDLE && calState == CAL_OFF && !calBusy)
      else $error("calibration end wrong");
   chk_cal_length: assert property (calState == CAL_WAIT && accept && calConv == '0
      |-> !calDone ##1 calState == CAL_WAIT)
      else $error("calibration ended early");

   cov_cont_exit: cover property (serState == SER_CONT ##1 serState == SER_CMD);
   cov_ones_reset: cover property (softRst);
   cov_fs_cal: cover property (calState == CAL_DIV ##1 calState == CAL_OFF);
   cov_word_read: cover property (readDone && serState == SER_CONT);
endmodule

//--- rtl/sdac_fifo2.sv
// Purpose: small word buffer between result scaling and the data register
// Assumes: one clock, synchronous reset
// Notes: read data is taken from the head entry
`timescale 1ns/1ps
module sdac_fifo2 #(
   parameter int W = 24,
   parameter int DEPTH = 2
) (
   // clock and reset
   input logic clk,
   input logic srst,
   // filling side
   input logic inValid,
   input logic [W-1:0] inData,
   output logic inReady,
   // draining side
   output logic outValid,
   output logic [W-1:0] outData,
   input logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

//--- rtl/sdac_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: one word width per build, chosen at the top module
// Notes: mode and channel codes are the three-bit field values
package sdac_pkg;
   // ------------------------------
   // widths and counts
   // ------------------------------
   localparam int WORD_W_DEF = 24;
   localparam int WORD_W_LOW = 16;
   localparam int FS_W = 24;
   localparam int FS_FRAC = 22;
   localparam logic [FS_W-1:0] FS_NOM = 24'h400000;
   localparam logic [WORD_W_DEF-1:0] OFFSET_DEF = 24'h000000;
   localparam int CMD_W = 8;
   localparam int ONES_RESET_BITS = 32;
   localparam int CAL_CONVS = 2;

   // ------------------------------
   // commands, modes, channels
   // ------------------------------
   localparam logic [CMD_W-1:0] CMD_READ_DATA = 8'h58;
   localparam logic [CMD_W-1:0] CMD_CONT_READ = 8'h5C;
   localparam logic [CMD_W-1:0] CMD_CONT_EXIT = 8'h58;
   localparam logic [2:0] MODE_CONT = 3'h0;
   localparam logic [2:0] MODE_SINGLE = 3'h1;
   localparam logic [2:0] MODE_IDLE = 3'h2;
   localparam logic [2:0] MODE_PDOWN = 3'h3;
   localparam logic [2:0] MODE_ZS_INT = 3'h4;
   localparam logic [2:0] MODE_ZS_SYS = 3'h6;
   localparam logic [2:0] MODE_FS_SYS = 3'h7;
   localparam logic [2:0] CHAN_SUPPLY = 3'h7;
   localparam logic [2:0] CHAN_TEMP = 3'h6;

   // ------------------------------
   // types
   // ------------------------------
   typedef struct packed {
      logic sclk;
      logic din;
      logic csN;
   } sdac_pins_t;
   localparam sdac_pins_t PINS_IDLE = 3'h5;

   typedef struct packed {
      logic unipolar;
      logic burnoutEnable;
      logic [2:0] channelSelect;
   } sdac_cfg_t;

   typedef struct packed {
      logic burnoutSource;
      logic burnoutSink;
      logic internalRef;
      logic supplyMonitor;
      logic tempSensor;
   } sdac_front_t;

   typedef enum logic [1:0] {SER_CMD = 2'h0, SER_OUT = 2'h1, SER_CONT = 2'h3} sdac_ser_t;
   typedef enum logic [1:0] {CAL_OFF = 2'h0, CAL_WAIT = 2'h1, CAL_DIV = 2'h3} sdac_cal_t;
endpackage

//--- sim/sdac_host.sv
// Purpose: host serial controller model driving the converter link
// Assumes: link clock period of 8 block clocks, idle high between frames
// Notes: bits go out MSB first; read bits are sampled just before each rise
`timescale 1ns/1ps
module sdac_host
   import sdac_pkg::*;
(
   // clock
   input logic clk,
   // serial pins
   output sdac_pkg::sdac_pins_t pins,
   input logic doutRdy
);
   initial pins = PINS_IDLE;

   // one framed transfer of n bits, chip select low throughout
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h00000000;
      pins.csN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         pins.sclk = 1'b0;
         pins.din = tx[i];
         repeat (4) @(posedge clk);
         #1;
         rx = {rx[30:0], doutRdy};
         pins.sclk = 1'b1;
         repeat (4) @(posedge clk);
         #1;
      end
      pins.csN = 1'b1;
      pins.din = 1'b0;
   endtask

   // quiet spell after any reset before touching the link
   task automatic settle();
      repeat (12500) @(posedge clk);
      #1;
   endtask
endmodule

//--- sim/testbench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: N of 24, host model on the serial pins
// Notes: expected codes are worked out by hand from the coding formulas
`timescale 1ns/1ps
module testbench;
   import sdac_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   sdac_pins_t pins;
   sdac_cfg_t cfg = 5'h00;
   logic modeLoad = 1'b0;
   logic [2:0] operatingMode = 3'h0;
   logic rawValid = 1'b0;
   logic signed [23:0] rawData = 24'h000000;
   logic doutRdy, doutRdyEn, calBusy, contRead, statusReadyN, analogReset, rawReady;
   logic [2:0] modeNow;
   sdac_front_t front;
   logic [23:0] dataWord, fullScaleCoef;
   logic signed [23:0] offsetCoef;
   logic [31:0] rx;
   int mismatches = 0;
   int samplesChecked = 0;

   always #20 clk = ~clk;

   sdac_host host (.clk(clk), .pins(pins), .doutRdy(doutRdy));
   sdac_control #(.N(24)) dut (.clk(clk), .srst(srst), .pins(pins), .doutRdy(doutRdy),
      .doutRdyEn(doutRdyEn), .cfg(cfg), .modeLoad(modeLoad), .operatingMode(operatingMode),
      .modeNow(modeNow), .calBusy(calBusy), .contRead(contRead),
      .statusReadyN(statusReadyN), .front(front), .analogReset(analogReset),
      .rawValid(rawValid), .rawData(rawData), .rawReady(rawReady), .dataWord(dataWord),
      .offsetCoef(offsetCoef), .fullScaleCoef(fullScaleCoef));

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // hand one filter word over, bounded wait for room
   task automatic feed(input logic [23:0] w);
      for (int i = 0; i < 20 && rawReady !== 1'b1; i++) tick(1);
      rawData = w;
      rawValid = 1'b1;
      tick(1);
      rawValid = 1'b0;
      tick(6);
   endtask

   task automatic testReset();
      chk("gain", 24'h400000, fullScaleCoef);
      chk("offset", 24'h000000, offsetCoef);
      chk("data", 24'h000000, dataWord);
      chk("mode", 24'(MODE_CONT), 24'(modeNow));
      chk("enable", 24'h000000, 24'(doutRdyEn));
      chk("room", 24'h000001, 24'(rawReady));
      chk("areset", 24'h000000, 24'(analogReset));
   endtask

   task automatic testFront();
      cfg = 5'h08;
      tick(2);
      chk("front", 24'h000018, 24'(front));
      cfg = 5'h07;
      tick(2);
      chk("front", 24'h000006, 24'(front));
      cfg = 5'h06;
      tick(2);
      chk("front", 24'h000005, 24'(front));
      cfg = 5'h00;
      tick(2);
      chk("front", 24'h000000, 24'(front));
   endtask

   task automatic testCoding();
      feed(24'h000000);
      chk("data", 24'h800000, dataWord);
      feed(24'h7FFFFF);
      chk("data", 24'hFFFFFF, dataWord);
      cfg = 5'h10;
      feed(24'h200000);
      chk("data", 24'h400000, dataWord);
      feed(24'h800000);
      chk("data", 24'h000000, dataWord);
      chk("ready", 24'h000000, 24'(statusReadyN));
      cfg = 5'h00;
   endtask

   task automatic testRead();
      feed(24'h123456);
      host.frame({CMD_READ_DATA, 24'h000000}, 32, rx);
      chk("serial", 24'h923456, rx[23:0]);
      tick(4);
      chk("ready", 24'h000001, 24'(statusReadyN));
   endtask

   // zero calibrations for both zero codes, then full scale
   task automatic testCal(input logic [2:0] m, input logic [23:0] w);
      operatingMode = m;
      modeLoad = 1'b1;
      tick(1);
      modeLoad = 1'b0;
      tick(1);
      chk("busy", 24'h000001, 24'(calBusy));
      chk("pin", 24'h000001, 24'(doutRdy));
      feed(w);
      chk("busy", 24'h000001, 24'(calBusy));
      feed(w);
      for (int i = 0; i < 80 && calBusy !== 1'b0; i++) tick(1);
      chk("ready", 24'h000000, 24'(statusReadyN));
      chk("mode", 24'(MODE_IDLE), 24'(modeNow));
   endtask

   task automatic testOnes();
      host.frame({24'h000000, CMD_CONT_READ}, 8, rx);
      tick(4);
      chk("cont", 24'h000001, 24'(contRead));
      host.frame(32'hFFFFFFFF, 32, rx);
      chk("areset", 24'h000001, 24'(analogReset));
      tick(4);
      chk("cont", 24'h000000, 24'(contRead));
      chk("gain", 24'h400000, fullScaleCoef);
      chk("offset", 24'h000000, offsetCoef);
      host.settle();
   endtask

   // single conversion, then words flow unasked in continuous read until exit
   task automatic testCont();
      operatingMode = MODE_SINGLE;
      modeLoad = 1'b1;
      tick(1);
      modeLoad = 1'b0;
      feed(24'h000001);
      chk("mode", 24'(MODE_PDOWN), 24'(modeNow));
      host.frame({24'h000000, CMD_CONT_READ}, 8, rx);
      tick(4);
      chk("pin", 24'h000000, 24'(doutRdy));
      host.frame(32'h00000000, 24, rx);
      chk("serial", 24'h800001, rx[23:0]);
      feed(24'h000002);
      host.frame({24'h000000, CMD_CONT_EXIT}, 8, rx);
      tick(4);
      chk("cont", 24'h000000, 24'(contRead));
   endtask

   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      tick(3);
      srst = 1'b0;
      host.settle();
      testReset();
      testFront();
      testCoding();
      testRead();
      testCal(MODE_ZS_INT, 24'h000200);
      chk("offset", 24'h000200, offsetCoef);
      testCal(MODE_ZS_SYS, 24'h000100);
      chk("offset", 24'h000100, offsetCoef);
      testCal(MODE_FS_SYS, 24'h400100);
      chk("gain", 24'h800000, fullScaleCoef);
      feed(24'h200100);
      chk("data", 24'hC00000, dataWord);
      testOnes();
      testCont();
      tallyAndFinish();
   end

   // watchdog well beyond the two reset pauses and the frames
   initial begin
      #3000000;
      mismatches++;
      tallyAndFinish();
   end
endmodule
